// ===== design/adc_pkg.sv
// Purpose: Shared constants for the converter control and result block.
// Assumes: 50 MHz ref_clk; 8-bit register offsets on a plain port.
// Notes: Offsets, bit positions, reset values and cycle counts live here.
package adc_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] OFS_CTL2 = 8'h62; // Power, flag and irq control
	localparam logic [7:0] OFS_CTL3 = 8'h63; // Length, FIFO and freeze
	localparam logic [7:0] OFS_CTL4 = 8'h64; // Sequence start A
	localparam logic [7:0] OFS_CTL5 = 8'h65; // Sequence start B
	localparam logic [7:0] OFS_STAT = 8'h66; // Converter status
	localparam logic [7:0] OFS_RES0 = 8'h70; // First of eight result regs

	// Field positions in control register two
	localparam int CTL2_PWR = 7; // Power up
	localparam int CTL2_FFC = 6; // Fast flag clear
	localparam int CTL2_SIW = 5; // Stop in wait
	localparam int CTL2_DJM = 4; // Justify select
	localparam int CTL2_IEN = 1; // Sequence done irq enable
	localparam int CTL2_IFL = 0; // Sequence done irq flag, read only

	// Field positions in control register three
	localparam int CTL3_S1C = 3; // Single length bit
	localparam int CTL3_FIFO = 2; // FIFO placement
	localparam int CTL3_FRZ_HI = 1; // Freeze select high
	localparam int CTL3_FRZ_LO = 0; // Freeze select low

	// Field positions in the start and status registers
	localparam int CTL4_RES = 7; // Resolution select
	localparam int CTL5_S8C = 6; // Eight length bit
	localparam int STAT_SCF = 7; // Sequence done flag

	// Reset values
	localparam logic [7:0] CTL2_RST = 8'h00; // Powered down
	localparam logic [3:0] CTL3_RST = 4'h0; // Four long, normal, no freeze

	// Freeze select encodings
	localparam logic [1:0] FRZ_RUN = 2'h0; // Keep converting
	localparam logic [1:0] FRZ_RSVD = 2'h1; // Reserved, runs on
	localparam logic [1:0] FRZ_FINISH = 2'h2; // Finish, then freeze
	localparam logic [1:0] FRZ_NOW = 2'h3; // Freeze at once

	// Last index of a sequence for each length
	localparam logic [2:0] LAST_LEN1 = 3'h0; // One conversion
	localparam logic [2:0] LAST_LEN4 = 3'h3; // Four conversions
	localparam logic [2:0] LAST_LEN8 = 3'h7; // Eight conversions

	// Conversion time and its cycle count
	localparam int CLK_PERIOD_NS = 20; // ref_clk period
	localparam int CONV_TIME_NS = 400; // One conversion, arbitrary model
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS; // Rounded up

	// Sequencer states
	typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} adc_state_t;

endpackage

// ===== design/adc_result_fmt.sv
// Purpose: Places a stored code on the 16-bit data bus.
// Assumes: Codes are held at 10 bits; 8-bit mode uses the top eight.
// Notes: Purely combinational; unmapped bits read zero.
`timescale 1ns/1ns
`default_nettype none
module adc_result_fmt
(
	input wire logic [9:0] code, // Stored conversion code
	input wire logic resolution_select, // High for 10-bit resolution
	input wire logic justify, // High for right justified
	output logic [15:0] data // Bus image of the result
);

	// Four formats; the rest of the word stays zero
	always_comb
	begin
		data = 16'h0000;
		if (resolution_select && !justify)
		begin
			data = {code, 6'h00};
		end
		else if (resolution_select)
		begin
			data = {6'h00, code};
		end
		else if (!justify)
		begin
			data = {code[9:2], 8'h00};
		end
		else
		begin
			data = {8'h00, code[9:2]};
		end
	end

endmodule
`default_nettype wire

// ===== design/adc_ctrl.sv
// Purpose: Control, flags and result placement of an on-chip converter.
// Assumes: Analog front end hands a code on conv_sample each cycle.
// Notes: Wait and debug halt inputs come from logic on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl
#(
	parameter int CONV_CYCLES = adc_pkg::CONV_CYCLES, // Cycles per result
	parameter int NUM_RES = 8 // Result registers
)
(
	input wire logic ref_clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic [7:0] addr, // Register address
	input wire logic [15:0] wdata, // Write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	output logic [15:0] rdata, // Read data, cycle after rd_stb
	input wire logic wait_mode, // Processor in wait
	input wire logic debug_halt_mode, // Debugger halt
	input wire logic [9:0] conv_sample, // Code from analog core
	output logic irq_req, // Sequence done interrupt
	output logic power_on, // Analog core powered
	output logic conv_busy // Sequence running
);

	localparam int PW = $clog2(NUM_RES); // Pointer width

	// Software state
	logic [7:0] ctl2_r, ctl2_nxt; // Control two, flag bit unused
	logic [3:0] ctl3_r, ctl3_nxt; // Control three fields
	logic resolution_select_r, resolution_select_nxt; // Resolution select
	logic s8c_r, s8c_nxt; // Eight length bit

	// Sequencer and flags
	adc_pkg::adc_state_t state_r, state_nxt; // Sequencer state
	logic [15:0] tmr_r, tmr_nxt; // Cycle within a conversion
	logic [2:0] idx_r, idx_nxt; // Conversion within a sequence
	logic [PW-1:0] ptr_r, ptr_nxt; // Result pointer
	logic [NUM_RES-1:0] ccf_r, ccf_nxt; // Conversion done flags
	logic [NUM_RES-1:0] arm_r, arm_nxt; // Seen by a status read
	logic scf_r, scf_nxt; // Sequence done flag
	logic ifl_r, ifl_nxt; // Sequence done irq flag

	// Outputs, all from flops
	logic [15:0] rdata_r, rdata_nxt; // Read data
	logic irq_r, irq_nxt; // Interrupt request
	logic pwr_r, pwr_nxt; // Power to analog core
	logic busy_r, busy_nxt; // Busy indication

	// Result storage
	logic [9:0] res_mem [NUM_RES]; // Stored codes
	logic res_we; // Store a code this cycle
	logic [15:0] fmt_data; // Formatted result

	// Decoded accesses
	logic start; // New sequence requested
	logic res_hit; // Address in result window
	logic [PW-1:0] res_idx; // Result register index
	logic halted; // Conversion clock stopped
	logic [2:0] last_idx; // Final index of the sequence
	logic frz_dbg; // Freeze request active

	// Address decode for the result window
	assign res_hit = (addr[7:3] == adc_pkg::OFS_RES0[7:3]);
	assign res_idx = addr[PW-1:0];
	assign start = wr_stb && ((addr == adc_pkg::OFS_CTL4)
		|| (addr == adc_pkg::OFS_CTL5));
	assign frz_dbg = debug_halt_mode;

	adc_result_fmt u_fmt
	(
		.code(res_mem[res_idx]),
		.resolution_select(resolution_select_r),
		.justify(ctl2_r[adc_pkg::CTL2_DJM]),
		.data(fmt_data)
	);

	// Sequence length from the two length bits
	always_comb
	begin
		if (s8c_r)
		begin
			last_idx = adc_pkg::LAST_LEN8;
		end
		else if (ctl3_r[adc_pkg::CTL3_S1C])
		begin
			last_idx = adc_pkg::LAST_LEN1;
		end
		else
		begin
			last_idx = adc_pkg::LAST_LEN4;
		end
	end

	// Halt when powered down, waiting, or frozen
	always_comb
	begin
		halted = !ctl2_r[adc_pkg::CTL2_PWR];
		if (ctl2_r[adc_pkg::CTL2_SIW] && wait_mode)
		begin
			halted = 1'b1;
		end
		if (frz_dbg && ctl3_r[1:0] == adc_pkg::FRZ_NOW)
		begin
			halted = 1'b1;
		end
		else if (frz_dbg && ctl3_r[1:0] == adc_pkg::FRZ_FINISH
			&& tmr_r == 16'h0000)
		begin
			halted = 1'b1;
		end
	end

	// Control registers; start register writes also restart the sequencer
	always_comb
	begin
		ctl2_nxt = ctl2_r;
		ctl3_nxt = ctl3_r;
		resolution_select_nxt = resolution_select_r;
		s8c_nxt = s8c_r;
		if (wr_stb && addr == adc_pkg::OFS_CTL2)
		begin
			// Flag bit and gaps are not writable
			ctl2_nxt = wdata[7:0] & 8'hF2;
		end
		else if (wr_stb && addr == adc_pkg::OFS_CTL3)
		begin
			ctl3_nxt = wdata[3:0];
		end
		else if (wr_stb && addr == adc_pkg::OFS_CTL4)
		begin
			resolution_select_nxt = wdata[adc_pkg::CTL4_RES];
		end
		else if (wr_stb && addr == adc_pkg::OFS_CTL5)
		begin
			s8c_nxt = wdata[adc_pkg::CTL5_S8C];
		end
	end

	// Sequencer, pointer and flags
	always_comb
	begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		idx_nxt = idx_r;
		ptr_nxt = ptr_r;
		ccf_nxt = ccf_r;
		arm_nxt = arm_r;
		scf_nxt = scf_r;
		ifl_nxt = ifl_r;
		res_we = 1'b0;
		// Status read arms every flag already set
		if (rd_stb && addr == adc_pkg::OFS_STAT)
		begin
			arm_nxt = arm_r | ccf_r;
		end
		// Result access clears its flag by the selected method
		if (res_hit && ctl2_r[adc_pkg::CTL2_FFC] && (rd_stb || wr_stb))
		begin
			ccf_nxt[res_idx] = 1'b0;
			arm_nxt[res_idx] = 1'b0;
			if (ccf_r[res_idx])
			begin
				ifl_nxt = 1'b0;
			end
			if (rd_stb)
			begin
				scf_nxt = 1'b0;
			end
		end
		else if (res_hit && rd_stb && arm_r[res_idx])
		begin
			ccf_nxt[res_idx] = 1'b0;
			arm_nxt[res_idx] = 1'b0;
			ifl_nxt = 1'b0;
		end
		// Conversion progress; a completion wins over a clear
		if (state_r == adc_pkg::ST_CONVERT && !halted)
		begin
			if (tmr_r == 16'(CONV_CYCLES - 1))
			begin
				res_we = 1'b1;
				tmr_nxt = 16'h0000;
				ccf_nxt[ptr_r] = 1'b1;
				arm_nxt[ptr_r] = 1'b0;
				ptr_nxt = ptr_r + 1'b1;
				idx_nxt = idx_r + 1'b1;
				if (idx_r == last_idx)
				begin
					// Sequence complete, no scan mode
					state_nxt = adc_pkg::ST_IDLE;
					scf_nxt = 1'b1;
					if (ctl2_r[adc_pkg::CTL2_IEN])
					begin
						ifl_nxt = 1'b1;
					end
					if (!ctl3_r[adc_pkg::CTL3_FIFO])
					begin
						ptr_nxt = '0;
					end
				end
			end
			else
			begin
				tmr_nxt = tmr_r + 16'h0001;
			end
		end
		// Start: restart, clears flags, pointer per placement mode
		if (start)
		begin
			state_nxt = adc_pkg::ST_CONVERT;
			tmr_nxt = 16'h0000;
			idx_nxt = 3'h0;
			ccf_nxt = '0;
			arm_nxt = '0;
			res_we = 1'b0;
			scf_nxt = 1'b0;
			ifl_nxt = 1'b0;
			if (!ctl3_r[adc_pkg::CTL3_FIFO])
			begin
				ptr_nxt = '0;
			end
			else
			begin
				ptr_nxt = ptr_r;
			end
		end
		// Power off aborts whatever is running
		if (!ctl2_r[adc_pkg::CTL2_PWR])
		begin
			state_nxt = adc_pkg::ST_IDLE;
			tmr_nxt = 16'h0000;
			res_we = 1'b0;
		end
	end

	// Read data and outputs
	always_comb
	begin
		rdata_nxt = 16'h0000;
		if (rd_stb && addr == adc_pkg::OFS_CTL2)
		begin
			rdata_nxt = {8'h00, ctl2_r[7:1], ifl_r};
		end
		else if (rd_stb && addr == adc_pkg::OFS_CTL3)
		begin
			rdata_nxt = {12'h000, ctl3_r};
		end
		else if (rd_stb && addr == adc_pkg::OFS_CTL4)
		begin
			rdata_nxt = {8'h00, resolution_select_r, 7'h00};
		end
		else if (rd_stb && addr == adc_pkg::OFS_CTL5)
		begin
			rdata_nxt = {9'h000, s8c_r, 6'h00};
		end
		else if (rd_stb && addr == adc_pkg::OFS_STAT)
		begin
			rdata_nxt = {8'h00, scf_r, 7'h00};
			rdata_nxt[15:8] = 8'(ccf_r);
			rdata_nxt[PW-1:0] = ptr_r;
		end
		else if (rd_stb && res_hit)
		begin
			rdata_nxt = fmt_data;
		end
		irq_nxt = ifl_r && ctl2_r[adc_pkg::CTL2_IEN];
		pwr_nxt = ctl2_r[adc_pkg::CTL2_PWR]
			&& !(ctl2_r[adc_pkg::CTL2_SIW] && wait_mode);
		busy_nxt = (state_r == adc_pkg::ST_CONVERT);
	end

	// Register stage for all groups except the result memory
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctl2_r <= adc_pkg::CTL2_RST;
			ctl3_r <= adc_pkg::CTL3_RST;
			resolution_select_r <= 1'b0;
			s8c_r <= 1'b0;
			state_r <= adc_pkg::ST_IDLE;
			tmr_r <= 16'h0000;
			idx_r <= 3'h0;
			ptr_r <= '0;
			ccf_r <= '0;
			arm_r <= '0;
			scf_r <= 1'b0;
			ifl_r <= 1'b0;
			rdata_r <= 16'h0000;
			irq_r <= 1'b0;
			pwr_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			ctl2_r <= ctl2_nxt;
			ctl3_r <= ctl3_nxt;
			resolution_select_r <= resolution_select_nxt;
			s8c_r <= s8c_nxt;
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			idx_r <= idx_nxt;
			ptr_r <= ptr_nxt;
			ccf_r <= ccf_nxt;
			arm_r <= arm_nxt;
			scf_r <= scf_nxt;
			ifl_r <= ifl_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			pwr_r <= pwr_nxt;
			busy_r <= busy_nxt;
		end
	end

	// Result memory needs no reset; flags say what is valid
	always_ff @(posedge ref_clk)
	begin
		if (res_we)
		begin
			res_mem[ptr_r] <= conv_sample;
		end
	end

	assign rdata = rdata_r;
	assign irq_req = irq_r;
	assign power_on = pwr_r;
	assign conv_busy = busy_r;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Power off write stops the sequence and the core together, two cycles after the write
	pwr_abort_a: assert property (
		wr_stb && addr == adc_pkg::OFS_CTL2 && !wdata[adc_pkg::CTL2_PWR]
		|=> ##1 state_r == adc_pkg::ST_IDLE && !power_on)
		else $error("power off did not abort");

	// Normal mode: unarmed read leaves the flag
	normal_clear_a: assert property (
		rd_stb && res_hit && !ctl2_r[adc_pkg::CTL2_FFC]
		&& ccf_r[res_idx] && !arm_r[res_idx]
		|=> ccf_r[$past(res_idx)])
		else $error("flag cleared without status read");

	// Fast mode: access clears unless a result lands there
	fast_clear_a: assert property (
		rd_stb && res_hit && ctl2_r[adc_pkg::CTL2_FFC] && !res_we
		|=> !ccf_r[$past(res_idx)])
		else $error("fast clear missed");

	// Start always drops the sequence flag, powered or not
	start_scf_a: assert property (
		start |=> !scf_r && (state_r == adc_pkg::ST_CONVERT
		|| !ctl2_r[adc_pkg::CTL2_PWR]))
		else $error("start left sequence flag set");

	// Wait with stop enabled holds the sequencer still
	// Power off zeroes the timer, so only a powered core is held
	wait_hold_a: assert property (
		ctl2_r[adc_pkg::CTL2_SIW] && wait_mode && !wr_stb
		&& ctl2_r[adc_pkg::CTL2_PWR]
		|=> $stable(tmr_r) && $stable(idx_r))
		else $error("converter ran in wait");

	// Disabled irq never requests
	irq_gate_a: assert property (
		!ctl2_r[adc_pkg::CTL2_IEN] && !wr_stb |=> ##1 !irq_req)
		else $error("irq raised while disabled");

	// Writing control two never changes the irq flag
	// A completion in the same cycle may still set it
	irq_ro_a: assert property (
		wr_stb && addr == adc_pkg::OFS_CTL2 && !res_we
		|=> ifl_r == $past(ifl_r))
		else $error("irq flag was written");

	// Single length ends the sequence after one result
	single_len_a: assert property (
		res_we && idx_r == 3'h0 && ctl3_r[adc_pkg::CTL3_S1C]
		&& !s8c_r && !start |=> state_r == adc_pkg::ST_IDLE)
		else $error("single sequence ran on");

	// Normal start zeroes the pointer
	ptr_zero_a: assert property (
		start && !ctl3_r[adc_pkg::CTL3_FIFO] |=> ptr_r == '0)
		else $error("pointer not zeroed");

	// Immediate freeze stops the timer
	freeze_now_a: assert property (
		frz_dbg && ctl3_r[1:0] == adc_pkg::FRZ_NOW && !wr_stb
		&& ctl2_r[adc_pkg::CTL2_PWR]
		|=> $stable(tmr_r))
		else $error("freeze ignored");

endmodule
`default_nettype wire

// ===== verif/adc_sequence_result_control_test.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: CONV_CYCLES cut to 2; eight result registers.
// Notes: Sequence ends are found by watching conv_busy fall.
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_result_control_test;
	localparam logic [7:0] C2 = adc_pkg::OFS_CTL2; // Control two
	localparam logic [7:0] C3 = adc_pkg::OFS_CTL3; // Control three
	localparam logic [7:0] C4 = adc_pkg::OFS_CTL4; // Start A
	localparam logic [7:0] C5 = adc_pkg::OFS_CTL5; // Start B
	localparam logic [7:0] ST = adc_pkg::OFS_STAT; // Status
	localparam logic [7:0] R0 = adc_pkg::OFS_RES0; // First result
	logic ref_clk, rst, wr_stb, rd_stb, wait_mode, debug_halt_mode;
	logic [7:0] addr; // Register address
	logic [15:0] wdata, rdata, d; // Bus data and last read
	logic [9:0] conv_sample; // Analog code, 2B5 except during one sequence at 155
	logic irq_req, power_on, conv_busy; // Status pins
	int mismatches, compares, i;
	// Result images: 8L, 8R, 10L, 10R
	logic [15:0] fm [4] = '{16'hAD00, 16'h00AD, 16'hAD40, 16'h02B5};
	// Status after S8C/S1C pairs 00, 01, 10, 11
	logic [15:0] ln [4] = '{16'h0F80, 16'h0180, 16'hFF80, 16'hFF80};

	adc_ctrl #(.CONV_CYCLES(2), .NUM_RES(8)) dut_u
	(
		.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.wait_mode(wait_mode), .debug_halt_mode(debug_halt_mode),
		.conv_sample(conv_sample), .irq_req(irq_req),
		.power_on(power_on), .conv_busy(conv_busy)
	);

	// 50 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Compare and count; report at once on a difference
	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= {8'h00, v};
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask

	// One-cycle read strobe; data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd(a, v);
		chk($sformatf("reg_%h", a), v, exp);
	endtask

	// Let n edges pass, then sample settled outputs
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Wait for the sequence to finish, bounded so a hang cannot stall
	task automatic sw();
		int n;
		n = 0;
		repeat (3) @(posedge ref_clk);
		#1;
		while (conv_busy !== 1'b0 && n < 300)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		// A sequence still running here is a hang
		chk("seq_end", {15'h0, conv_busy}, 16'h0000);
		tk(3);
	endtask

	task automatic report_and_stop();
		$display("Counts: %0d compares, %0d mismatches", compares,
			mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog, far beyond the several hundred cycles the tests need
	initial
	begin
		#1000000;
		mismatches++;
		report_and_stop();
	end

	initial
	begin
		{rst, wr_stb, rd_stb, wait_mode, debug_halt_mode} = 5'h10;
		addr = 8'h00;
		wdata = 16'h0000;
		conv_sample = 10'h2B5;
		mismatches = 0;
		compares = 0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rc(C2, 16'h0000);
		rc(C3, 16'h0000);
		rc(ST, 16'h0000);
		chk("power_on", {15'h0, power_on}, 16'h0000);
		rc(8'h5F, 16'h0000);
		wr(C3, 8'hFF);
		rc(C3, 16'h000F);
		wr(C2, 8'hFF);
		rc(C2, 16'h00F2);
		tk(2);
		chk("power_on", {15'h0, power_on}, 16'h0001);
		$display("reset and access test done");
		// Formats; reads without a status read leave flags alone
		wr(C3, 8'h08);
		for (i = 0; i < 4; i++)
		begin
			wr(C2, {3'b100, i[0], 4'h0});
			wr(C4, {i[1], 7'h00});
			sw();
			rc(R0, fm[i]);
		end
		rc(ST, 16'h0180);
		rc(R0, 16'h02B5);
		rc(ST, 16'h0080);
		$display("format test done");
		wr(C2, 8'hC0);
		wr(C3, 8'h00);
		wr(C5, 8'h00);
		sw();
		rc(ST, 16'h0F80);
		wr(R0 + 8'h01, 8'h00);
		rc(ST, 16'h0D80);
		rc(R0, 16'hAD40);
		rc(ST, 16'h0C00);
		$display("fast clear test done");
		wr(C2, 8'h80);
		for (i = 0; i < 4; i++)
		begin
			wr(C3, {4'h0, i[0], 3'h0});
			wr(C5, {1'b0, i[1], 6'h00});
			sw();
			rc(ST, ln[i]);
		end
		// FIFO pointer runs on across sequences and wraps
		wr(C3, 8'h0C);
		wr(C5, 8'h00);
		sw();
		rc(ST, 16'h0181);
		// A second code shows which register each result lands in
		@(posedge ref_clk);
		conv_sample <= 10'h155;
		wr(C5, 8'h00);
		sw();
		rc(ST, 16'h0282);
		rc(R0 + 8'h01, 16'h5540);
		rc(R0, 16'hAD40);
		@(posedge ref_clk);
		conv_sample <= 10'h2B5;
		wr(C3, 8'h04);
		wr(C5, 8'h00);
		sw();
		rc(ST, 16'h3C86);
		wr(C5, 8'h00);
		sw();
		rc(ST, 16'hC382);
		wr(C3, 8'h08);
		wr(C5, 8'h00);
		sw();
		rc(ST, 16'h0180);
		$display("length and pointer test done");
		wr(C2, 8'h82);
		wr(C5, 8'h00);
		sw();
		chk("irq_req", {15'h0, irq_req}, 16'h0001);
		rc(C2, 16'h0083);
		wr(C2, 8'h82);
		rc(C2, 16'h0083);
		rc(ST, 16'h0180);
		rc(R0, 16'hAD40);
		tk(2);
		chk("irq_req", {15'h0, irq_req}, 16'h0000);
		rc(C2, 16'h0082);
		wr(C2, 8'h80);
		wr(C5, 8'h00);
		sw();
		chk("irq_req", {15'h0, irq_req}, 16'h0000);
		rc(C2, 16'h0080);
		// Start while powered down clears flags and runs nothing
		wr(C2, 8'h00);
		wr(C5, 8'h00);
		tk(30);
		rc(ST, 16'h0000);
		$display("irq test done");
		wr(C2, 8'h80);
		wr(C3, 8'h00);
		wr(C5, 8'h40);
		wr(C3, 8'h00);
		tk(1);
		chk("conv_busy", {15'h0, conv_busy}, 16'h0001);
		wr(C2, 8'h00);
		tk(3);
		chk("power_on", {15'h0, power_on}, 16'h0000);
		chk("conv_busy", {15'h0, conv_busy}, 16'h0000);
		tk(40);
		rd(ST, d);
		chk("seq_done", {15'h0, d[7]}, 16'h0000);
		$display("abort test done");
		wr(C2, 8'hA0);
		wr(C5, 8'h40);
		@(posedge ref_clk);
		wait_mode <= 1'b1;
		tk(3);
		chk("power_on", {15'h0, power_on}, 16'h0000);
		tk(40);
		chk("conv_busy", {15'h0, conv_busy}, 16'h0001);
		@(posedge ref_clk);
		wait_mode <= 1'b0;
		tk(3);
		chk("power_on", {15'h0, power_on}, 16'h0001);
		sw();
		rc(ST, 16'hFF80);
		wr(C2, 8'h80);
		wr(C5, 8'h40);
		@(posedge ref_clk);
		wait_mode <= 1'b1;
		sw();
		chk("power_on", {15'h0, power_on}, 16'h0001);
		rc(ST, 16'hFF80);
		@(posedge ref_clk);
		wait_mode <= 1'b0;
		// Settle gap after wait before the next start
		tk(4);
		$display("wait test done");
		// Freeze codes 2 and 3 hold the sequence, 0 and 1 run on
		for (i = 0; i < 4; i++)
		begin
			wr(C3, {6'h00, i[1:0]});
			wr(C5, 8'h40);
			@(posedge ref_clk);
			debug_halt_mode <= 1'b1;
			tk(60);
			rd(ST, d);
			chk("seq_done", {15'h0, d[7]}, {15'h0, ~i[1]});
			@(posedge ref_clk);
			debug_halt_mode <= 1'b0;
			sw();
			rc(ST, 16'hFF80);
		end
		$display("freeze test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
